// >>> pkg/otpbl_pkg.sv
// Purpose: shared constants, types and helpers for the OTP region and block lock command logic
// Assumes: single-bit serial link, opcode then 24-bit address, MSB first
// Notes: lock map is 16 low sectors, 126 middle blocks, 16 high sectors
//
// Overview of operation
// - opcode 44h plus 24-bit address erases one security register
// - erase refused unless the write latch flag is set
// - erase runs only if select rises right after the 32nd bit
// - erase is self-timed; busy stays 1 throughout, then 0; status reads allowed
// - erase completion clears the write latch flag
// - a set OTP lock bit makes erase of that register ignored
// - a set OTP lock bit makes program of that register ignored
// - opcode 42h, address, 1 to 256 data bytes; host programs erased bytes
// - program refused unless the write latch flag is set
// - register chosen by middle byte 10h, 20h, 30h; low byte is offset
// - opcode 48h, address, eight dummy clocks; data out MSB first on falling edges
// - read offset increments per byte and wraps FFh to 00h
// - read with nonzero top address byte returns arbitrary data
// - block lock bits protect only when protect scheme select is 1
// - all block lock bits are 1 after power-up or reset
// - opcode 36h plus address sets the addressed block lock bit
// - opcode 39h plus address clears the addressed block lock bit
// - opcode 3Dh plus address shifts out lock byte, LSB is lock state
// - opcode 7Eh alone sets every block lock bit
// - opcode 98h alone clears every block lock bit
// - individual lock and unlock need the write latch flag
// - global lock and unlock need the write latch flag

package otpbl_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_OTP_ERASE = 8'h44;
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h48;
  localparam logic [7:0] OP_BLK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_BLK_LOCK_RD = 8'h3D;
  localparam logic [7:0] OP_GLB_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLB_UNLOCK = 8'h98;

  // ==========================================================
  // frame bit positions
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] LOCK_FETCH_BITS = 6'h14;
  localparam logic [5:0] ADDR_END = 6'h20;
  localparam logic [5:0] DUMMY_END = 6'h28;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // security register map
  localparam logic [7:0] OTP_TOP_BYTE = 8'h00;
  localparam logic [7:0] OTP_REG1_MID = 8'h10;
  localparam logic [7:0] OTP_REG2_MID = 8'h20;
  localparam logic [7:0] OTP_REG3_MID = 8'h30;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] LAST_OFFSET = 8'hFF;
  localparam int OTP_REGS = 3;
  localparam int OTP_BYTES = 256;
  localparam int OTP_AW = 10;

  // ==========================================================
  // block lock map
  localparam int LOCK_COUNT = 158;
  localparam logic [6:0] LAST_BLOCK = 7'h7F;
  localparam logic [7:0] MID_BASE = 8'h0F;
  localparam logic [7:0] HIGH_BASE = 8'h8E;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US = 1000;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_FDONE = 3'h3,
    S_PRD = 3'h2,
    S_PWR = 3'h6,
    S_ERASE = 3'h4,
    S_ETIME = 3'h5
  } otpbl_state_type;

  typedef struct packed {
    logic lock_kind;
    logic [23:0] addr;
  } otpbl_fetch_type;

  typedef struct packed {
    logic [7:0] off;
    logic [7:0] data;
  } otpbl_wr_type;

  function automatic logic otpbl_valid(input logic [23:0] a);
    otpbl_valid = (a[23:16] == OTP_TOP_BYTE) && ((a[15:8] == OTP_REG1_MID)
      || (a[15:8] == OTP_REG2_MID) || (a[15:8] == OTP_REG3_MID));
  endfunction : otpbl_valid

  // out-of-map middle bytes fold onto a register chosen by address bits 13:12
  function automatic logic [1:0] otpbl_slot(input logic [23:0] a);
    otpbl_slot = (a[13:12] == 2'h0) ? 2'h0 : 2'(a[13:12] - 2'h1);
  endfunction : otpbl_slot

  function automatic logic [7:0] otpbl_lock_index(input logic [23:0] a);
    if (a[22:16] == 7'h00)
    begin
      otpbl_lock_index = {4'h0, a[15:12]};
    end
    else if (a[22:16] == LAST_BLOCK)
    begin
      otpbl_lock_index = 8'(HIGH_BASE + {4'h0, a[15:12]});
    end
    else
    begin
      otpbl_lock_index = 8'(MID_BASE + {1'b0, a[22:16]});
    end
  endfunction : otpbl_lock_index

endpackage : otpbl_pkg

// >>> design/otpbl_mem.sv
// Purpose: byte store for the three security registers
// Assumes: one port, write or read each cycle
// Notes: read data registered, one cycle after the address
`timescale 1ns/1ns
`default_nettype none

module otpbl_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 768,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule : otpbl_mem
`default_nettype wire

// >>> design/otpbl_core.sv
// Purpose: OTP region erase/program/read and volatile block lock commands
// Assumes: link logic on sclk, control on mclk; sclk still between frames
// Notes: frame length is read by mclk only after select has risen; fetch and write requests cross mid-frame by toggles
`timescale 1ns/1ns
`default_nettype none

module otpbl_core #(
  parameter int OTP_ERASE_TIME_US = 100
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic so_data_q,
  output logic so_oe_n_q,
  input wire logic wel_set,
  output logic write_latch_flag_q,
  output logic busy_q,
  input wire logic [otpbl_pkg::OTP_REGS-1:0] otp_lock_bits,
  input wire logic protect_scheme_select,
  input wire logic range_protected,
  input wire logic [23:0] check_addr,
  output logic write_protected_q
);
  import otpbl_pkg::*;

  localparam int ERASE_RAW = OTP_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (ERASE_RAW < 1) ? 1 : ERASE_RAW;
  localparam logic [19:0] ERASE_LAST = 20'(ERASE_CYCLES - 1);

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // link side, sclk domain
  logic link_idle;
  logic fresh_q;
  logic [5:0] cnt_q;
  logic [2:0] bcnt_q;
  logic [31:0] sh_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] off_q;
  otpbl_fetch_type fetch_q;
  logic fetch_tgl_q;
  otpbl_wr_type wr_q;
  logic wr_tgl_q;
  logic [7:0] out_sh_q;
  logic [7:0] rsp_q;

  assign link_idle = cs_n | ~rst_q;

  wire [7:0] byte_in = {sh_q[6:0], serial_in};
  wire bnd = !fresh_q && (bcnt_q == LAST_BIT) && (cnt_q >= DUMMY_END - 6'h01);
  wire addr_done = !fresh_q && (cnt_q == ADDR_END - 6'h01);
  wire [5:0] cnt_d = fresh_q ? 6'h01 : ((cnt_q == DUMMY_END) ? cnt_q : 6'(cnt_q + 6'h01));
  wire out_phase = ((opc_q == OP_OTP_READ) && (cnt_q == DUMMY_END))
    || ((opc_q == OP_BLK_LOCK_RD) && (cnt_q >= ADDR_END));

  always_ff @(posedge sclk or posedge link_idle)
  begin
    if (link_idle)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  always_ff @(posedge sclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      cnt_q <= '0;
      bcnt_q <= '0;
      sh_q <= '0;
      opc_q <= '0;
      addr_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      bcnt_q <= fresh_q ? 3'h1 : 3'(bcnt_q + 3'h1);
      sh_q <= fresh_q ? {31'h0000_0000, serial_in} : {sh_q[30:0], serial_in};
      if (!fresh_q && (cnt_q == OPC_BITS - 6'h01))
        opc_q <= byte_in;
      if (addr_done)
        addr_q <= {sh_q[22:0], serial_in};
    end
  end

  always_ff @(posedge sclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      off_q <= '0;
      fetch_q <= '0;
      fetch_tgl_q <= 1'b0;
      wr_q <= '0;
      wr_tgl_q <= 1'b0;
    end
    else
    begin
      if (addr_done)
        off_q <= byte_in;
      else if (bnd)
        off_q <= 8'(off_q + 8'h01);
      if (!fresh_q && (cnt_q == LOCK_FETCH_BITS - 6'h01) && (opc_q == OP_BLK_LOCK_RD))
      begin
        fetch_q <= '{lock_kind: 1'b1, addr: {sh_q[10:0], serial_in, 12'h000}};
        fetch_tgl_q <= ~fetch_tgl_q;
      end
      else if (addr_done && (opc_q == OP_OTP_READ))
      begin
        fetch_q <= '{lock_kind: 1'b0, addr: {sh_q[22:0], serial_in}};
        fetch_tgl_q <= ~fetch_tgl_q;
      end
      else if (bnd && (opc_q == OP_OTP_READ))
      begin
        fetch_q <= '{lock_kind: 1'b0, addr: {addr_q[23:8], 8'(off_q + 8'h01)}};
        fetch_tgl_q <= ~fetch_tgl_q;
      end
      // one write event per data byte
      if (bnd && (opc_q == OP_OTP_PROG))
      begin
        wr_q <= '{off: off_q, data: byte_in};
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  always_ff @(negedge sclk or posedge link_idle)
  begin
    if (link_idle)
    begin
      out_sh_q <= '0;
      so_data_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
    else if (out_phase)
    begin
      so_oe_n_q <= 1'b0;
      if (bcnt_q == 3'h0)
      begin
        so_data_q <= rsp_q[7];
        out_sh_q <= {rsp_q[6:0], 1'b0};
      end
      else
      begin
        so_data_q <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // crossings into mclk
  logic [2:0] cs_s_q;
  logic [2:0] ft_s_q;
  logic [2:0] wt_s_q;

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      cs_s_q <= 3'h7;
      ft_s_q <= '0;
      wt_s_q <= '0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[1:0], cs_n};
      ft_s_q <= {ft_s_q[1:0], fetch_tgl_q};
      wt_s_q <= {wt_s_q[1:0], wr_tgl_q};
    end
  end

  wire frame_end = cs_s_q[1] & ~cs_s_q[2];
  wire fetch_ev = ft_s_q[1] ^ ft_s_q[2];
  wire wr_ev = wt_s_q[1] ^ wt_s_q[2];

  // ==========================================================
  // command decision, mclk domain
  otpbl_state_type state_q;
  otpbl_state_type state_d;
  logic exec_pend_q;
  logic fetch_pend_q;
  logic wr_pend_q;
  logic wel_q;
  logic [LOCK_COUNT-1:0] lock_q;
  logic [7:0] ptr_q;
  logic [19:0] timer_q;
  logic [1:0] er_slot_q;
  logic [7:0] mem_rdata;

  wire [1:0] cmd_slot = otpbl_slot(addr_q);
  wire cmd_locked = otp_lock_bits[cmd_slot];
  wire cmd_valid = otpbl_valid(addr_q);
  wire exec_take = (state_q == S_IDLE) && exec_pend_q;
  wire len_addr = (cnt_q == ADDR_END);
  wire len_opc = (cnt_q == OPC_BITS);
  wire erase_go = exec_take && (opc_q == OP_OTP_ERASE) && len_addr && wel_q
    && cmd_valid && !cmd_locked;
  wire blk_go = exec_take && len_addr && wel_q;
  wire lock_go = blk_go && (opc_q == OP_BLK_LOCK);
  wire unlock_go = blk_go && (opc_q == OP_BLK_UNLOCK);
  wire glock_go = exec_take && len_opc && wel_q && (opc_q == OP_GLB_LOCK);
  wire gunlock_go = exec_take && len_opc && wel_q && (opc_q == OP_GLB_UNLOCK);
  wire prog_ok = (opc_q == OP_OTP_PROG) && wel_q && cmd_valid && !cmd_locked;
  wire fetch_take = (state_q == S_IDLE) && !exec_pend_q && fetch_pend_q;
  wire wr_take = (state_q == S_IDLE) && !exec_pend_q && !fetch_pend_q && wr_pend_q;
  wire erase_done = (state_q == S_ETIME) && (timer_q == ERASE_LAST);
  wire [7:0] lock_idx = otpbl_lock_index(addr_q);
  wire [7:0] chk_idx = otpbl_lock_index(check_addr);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
        if (erase_go)
          state_d = S_ERASE;
        else if (fetch_take)
          state_d = S_FETCH;
        else if (wr_take && prog_ok)
          state_d = S_PRD;
      S_FETCH: state_d = S_FDONE;
      S_FDONE: state_d = S_IDLE;
      S_PRD: state_d = S_PWR;
      S_PWR: state_d = S_IDLE;
      S_ERASE:
        if (ptr_q == LAST_OFFSET)
          state_d = S_ETIME;
      S_ETIME:
        if (erase_done)
          state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // memory port selection
  wire mem_we = (state_q == S_ERASE) || (state_q == S_PWR);
  wire [OTP_AW-1:0] mem_addr = (state_q == S_ERASE) ? {er_slot_q, ptr_q}
    : (state_q == S_FETCH) ? {otpbl_slot(fetch_q.addr), fetch_q.addr[7:0]}
    : {cmd_slot, wr_q.off};
  // programming only clears bits
  wire [7:0] mem_wdata = (state_q == S_ERASE) ? ERASED_BYTE : (mem_rdata & wr_q.data);

  otpbl_mem #(
    .WIDTH(8),
    .DEPTH(OTP_REGS * OTP_BYTES),
    .AW(OTP_AW)
  ) u_mem (
    .clk(mclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  // frames and program bytes during busy are dropped, not queued; read fetches wait
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      exec_pend_q <= 1'b0;
      fetch_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end
    else
    begin
      exec_pend_q <= (frame_end & ~busy_q) | (exec_pend_q & ~exec_take);
      fetch_pend_q <= fetch_ev | (fetch_pend_q & ~fetch_take);
      wr_pend_q <= (wr_ev & ~busy_q) | (wr_pend_q & ~wr_take);
    end
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q <= S_IDLE;
      ptr_q <= '0;
      timer_q <= '0;
      er_slot_q <= '0;
      rsp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= (state_q == S_ERASE) ? 8'(ptr_q + 8'h01) : 8'h00;
      timer_q <= (state_q == S_ETIME) ? 20'(timer_q + 20'h1) : 20'h0;
      if (erase_go)
        er_slot_q <= cmd_slot;
      // unmapped read addresses give whatever folds in
      if (state_q == S_FDONE)
        rsp_q <= fetch_q.lock_kind ? {7'h00, lock_q[otpbl_lock_index(fetch_q.addr)]}
          : mem_rdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      busy_q <= 1'b0;
    else if (erase_go)
      busy_q <= 1'b1;
    else if (erase_done)
      busy_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      wel_q <= 1'b0;
    else if (wel_set)
      wel_q <= 1'b1;
    else if (erase_done)
      wel_q <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      lock_q <= '1;
    else if (glock_go)
      lock_q <= '1;
    else if (gunlock_go)
      lock_q <= '0;
    else if (lock_go)
      lock_q[lock_idx] <= 1'b1;
    else if (unlock_go)
      lock_q[lock_idx] <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      write_protected_q <= 1'b1;
    else
      write_protected_q <= protect_scheme_select ? lock_q[chk_idx] : range_protected;
  end

  assign write_latch_flag_q = wel_q;

  // ==========================================================
  // checks
  property p_erase_wel;
    @(posedge mclk) disable iff (!rst_q)
    (state_q == S_IDLE && state_d == S_ERASE) |-> wel_q;
  endproperty
  a_erase_wel: assert property (p_erase_wel) else $error("erase started without latch");

  property p_erase_len;
    @(posedge mclk) disable iff (!rst_q)
    (state_q == S_IDLE && state_d == S_ERASE) |-> (cnt_q == ADDR_END && opc_q == OP_OTP_ERASE);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase on wrong frame length");

  property p_busy_hold;
    @(posedge mclk) disable iff (!rst_q)
    $rose(busy_q) |-> busy_q [*8] ##1 (state_q == S_ERASE);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end_wel;
    @(posedge mclk) disable iff (!rst_q)
    $fell(busy_q) |-> ($past(state_q) == S_ETIME) && (!wel_q || $past(wel_set));
  endproperty
  a_busy_end_wel: assert property (p_busy_end_wel) else $error("latch kept after erase");

  property p_erase_lock;
    @(posedge mclk) disable iff (!rst_q)
    (state_q == S_IDLE && state_d == S_ERASE) |-> !otp_lock_bits[cmd_slot];
  endproperty
  a_erase_lock: assert property (p_erase_lock) else $error("erase of locked register");

  property p_prog_lock;
    @(posedge mclk) disable iff (!rst_q)
    (state_q == S_IDLE && state_d == S_PRD) |-> ##1 (state_q == S_PRD) ##1 mem_we
      && !otp_lock_bits[cmd_slot];
  endproperty
  a_prog_lock: assert property (p_prog_lock) else $error("program of locked register");

  property p_prog_wel;
    @(posedge mclk) disable iff (!rst_q)
    (state_q == S_PWR) |-> $past(wel_q, 2);
  endproperty
  a_prog_wel: assert property (p_prog_wel) else $error("program without latch");

  property p_lock_wel;
    @(posedge mclk) disable iff (!rst_q)
    (lock_q != $past(lock_q)) |-> $past(wel_q) && $past(exec_take);
  endproperty
  a_lock_wel: assert property (p_lock_wel) else $error("lock bits moved without latch");

  property p_glock;
    @(posedge mclk) disable iff (!rst_q)
    glock_go |=> (&lock_q);
  endproperty
  a_glock: assert property (p_glock) else $error("global lock incomplete");

  property p_gunlock;
    @(posedge mclk) disable iff (!rst_q)
    gunlock_go |=> (lock_q == '0);
  endproperty
  a_gunlock: assert property (p_gunlock) else $error("global unlock incomplete");

  property p_reset_locks;
    @(posedge mclk) disable iff (!rst_q)
    $rose(rst_q) |-> (&lock_q) && !busy_q;
  endproperty
  a_reset_locks: assert property (p_reset_locks) else $error("locks not set after reset");

endmodule : otpbl_core
`default_nettype wire

// >>> test/otpbl_host.sv
// Purpose: host link controller model for the otp and block lock logic
// Assumes: link clock half period 16 ns, clock still between frames
// Notes: data line shows the inverse of its last bit outside frames
`timescale 1ns/1ns
`default_nettype none

module otpbl_host (
  output logic cs_n,
  output logic sclk,
  output logic serial_in,
  input wire logic so_data_q,
  input wire logic so_oe_n_q
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  // select held low from here to stop
  task automatic start();
    cs_n = 1'b0;
    #16;
  endtask : start

  // ==========================================================
  // shifting
  // msb first, set while clock low, captured on rising
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = v[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask : put

  // sampled mid-way through clock low, 8 ns after the falling launch
  task automatic get(output logic [7:0] b, output logic oe_n);
    oe_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #8 b[i] = so_data_q;
      oe_n = oe_n | so_oe_n_q;
      #8 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask : get

  // select rises only after the last whole bit
  task automatic stop();
    #16 cs_n = 1'b1;
    serial_in = ~serial_in;
    #800;
  endtask : stop

endmodule : otpbl_host
`default_nettype wire

// >>> test/tb_otpbl_core.sv
// Purpose: self-checking bench for the otp region and block lock logic
// Assumes: erase time parameter 1 us, so an erase lasts about 281 cycles
// Notes: only security register two is erased, others stay undefined
`timescale 1ns/1ns
`default_nettype none

module tb_otpbl_core;
  import otpbl_pkg::*;
  logic mclk, rst_n, wel_set, scheme, range_p, cs_n, sclk, serial_in;
  logic so_d, so_oe_n, wlf, busy, wp, oe;
  logic [OTP_REGS-1:0] lockb;
  logic [23:0] chk_a;
  logic [7:0] q [3];
  int failures, cmp_count, cyc, n;

  otpbl_core #(.OTP_ERASE_TIME_US(1)) otpbl_core_inst (.mclk(mclk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .so_data_q(so_d),
    .so_oe_n_q(so_oe_n), .wel_set(wel_set), .write_latch_flag_q(wlf), .busy_q(busy),
    .otp_lock_bits(lockb), .protect_scheme_select(scheme), .range_protected(range_p),
    .check_addr(chk_a), .write_protected_q(wp));
  otpbl_host otpbl_host_inst (.cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
    .so_data_q(so_d), .so_oe_n_q(so_oe_n));

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic write_latch_flag();
    @(posedge mclk);
    #2 wel_set = 1'b1;
    @(posedge mclk);
    #2 wel_set = 1'b0;
  endtask : write_latch_flag

  task automatic frame(input logic [31:0] v, input int bits);
    otpbl_host_inst.start();
    otpbl_host_inst.put(v, bits);
    otpbl_host_inst.stop();
  endtask : frame

  task automatic rd(input logic [31:0] v, input int dum);
    otpbl_host_inst.start();
    otpbl_host_inst.put(v, 32);
    otpbl_host_inst.put(32'h0000_0000, dum);
    for (int i = 0; i < 3; i++)
    begin
      otpbl_host_inst.get(q[i], oe);
      chk(oe, 1'b0);
    end
    otpbl_host_inst.stop();
    chk(so_oe_n, 1'b1);
  endtask : rd

  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(posedge mclk);
      n++;
    end
    #2;
  endtask : wait_idle

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk(wp, 1'b1);
    chk(busy, 1'b0);
    frame(32'h0000_0098, 8);
    chk(wp, 1'b1);
    frame({8'h39, chk_a}, 32);
    chk(wp, 1'b1);
  endtask : t_reset

  task automatic t_blocks();
    write_latch_flag();
    frame(32'h0000_0098, 8);
    chk(wp, 1'b0);
    frame({8'h36, chk_a}, 32);
    chk(wp, 1'b1);
    rd({8'h3D, chk_a}, 0);
    chk(q[0][0], 1'b1);
    chk(q[1][0], 1'b1);
    rd(32'h3D06_0000, 0);
    chk(q[0][0], 1'b0);
    // block locked here, so range input alone must decide
    @(posedge mclk);
    #2 scheme = 1'b0;
    repeat (3) @(posedge mclk);
    #2 chk(wp, 1'b0);
    range_p = 1'b1;
    repeat (3) @(posedge mclk);
    #2 chk(wp, 1'b1);
    range_p = 1'b0;
    scheme = 1'b1;
    frame({8'h39, chk_a}, 32);
    chk(wp, 1'b0);
    frame(32'h0000_007E, 8);
    chk(wp, 1'b1);
  endtask : t_blocks

  task automatic t_erase();
    otpbl_host_inst.start();
    otpbl_host_inst.put(32'h4400_2000, 32);
    otpbl_host_inst.put(32'h0000_0000, 1);
    otpbl_host_inst.stop();
    chk(busy, 1'b0);
    frame(32'h4400_4000, 32);
    chk(busy, 1'b0);
    frame(32'h4400_2000, 32);
    chk(busy, 1'b1);
    wait_idle();
    // about 256 clearing plus 25 timed cycles remain
    chk(n > 200 && n < 300, 1'b1);
    chk(wlf, 1'b0);
    frame(32'h4400_2000, 32);
    chk(busy, 1'b0);
  endtask : t_erase

  task automatic t_prog();
    otpbl_host_inst.start();
    otpbl_host_inst.put(32'h4200_2010, 32);
    otpbl_host_inst.put(32'h0000_0000, 8);
    otpbl_host_inst.stop();
    rd(32'h4800_2010, 8);
    chk(q[0], 8'hFF);
    write_latch_flag();
    otpbl_host_inst.start();
    otpbl_host_inst.put(32'h4200_20FE, 32);
    otpbl_host_inst.put(32'h00A5_3C5A, 24);
    otpbl_host_inst.stop();
    rd(32'h4800_20FE, 8);
    chk(q[0], 8'hA5);
    chk(q[1], 8'h3C);
    chk(q[2], 8'h5A);
  endtask : t_prog

  task automatic t_otp_lock();
    #2 lockb = 3'b010;
    otpbl_host_inst.start();
    otpbl_host_inst.put(32'h4200_2020, 32);
    otpbl_host_inst.put(32'h0000_0000, 8);
    otpbl_host_inst.stop();
    rd(32'h4800_2020, 8);
    chk(q[0], 8'hFF);
    frame(32'h4400_2000, 32);
    chk(busy, 1'b0);
    rd(32'h4800_20FE, 8);
    chk(q[0], 8'hA5);
  endtask : t_otp_lock

  // second reset in mid-run, with the blocks unlocked beforehand
  task automatic t_midreset();
    write_latch_flag();
    frame(32'h0000_0098, 8);
    chk(wp, 1'b0);
    @(posedge mclk);
    #2 rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #2 chk(wp, 1'b1);
    chk(busy, 1'b0);
    frame({8'h39, chk_a}, 32);
    chk(wp, 1'b1);
  endtask : t_midreset

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    wel_set = 1'b0;
    scheme = 1'b1;
    range_p = 1'b0;
    lockb = 3'b000;
    chk_a = 24'h05_0000;
    repeat (20) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge mclk);
    #2;
    t_reset();
    t_blocks();
    t_erase();
    t_prog();
    t_otp_lock();
    t_midreset();
    final_report();
  end

endmodule : tb_otpbl_core
`default_nettype wire
